/* File: shared/dpb_pkg.sv */
// Types shared by the dual-port memory write controller
package dpb_pkg;
  typedef enum logic [2:0] {
    DPB_IDLE,
    DPB_SETUP,
    DPB_STROBE,
    DPB_HOLD,
    DPB_RECOVER
  } dpb_state_t;
endpackage : dpb_pkg

/* File: shared/dpb_regs.svh */
// Timing constants for the dual-port memory write controller
`ifndef DPB_REGS_SVH
`define DPB_REGS_SVH
`define DPB_CLK_PERIOD_NS 25
`define DPB_WRITE_PULSE_NS 55
`define DPB_HIGHZ_NS 40
`define DPB_DATA_SETUP_NS 40
`define DPB_WRITE_HOLD_AFTER_BUSY_NS 20
`define DPB_BUSY_ASSERT_FROM_SELECT_NS 50
`define DPB_BUSY_RELEASE_FROM_SELECT_NS 50
`define DPB_CYC_UP(ns) (((ns) + `DPB_CLK_PERIOD_NS - 1) / `DPB_CLK_PERIOD_NS)
`define DPB_MAXI(a, b) (((a) > (b)) ? (a) : (b))
`define DPB_PULSE_CYC `DPB_CYC_UP(`DPB_MAXI(`DPB_WRITE_PULSE_NS, `DPB_HIGHZ_NS + `DPB_DATA_SETUP_NS))
`define DPB_BUSY_WAIT_CYC `DPB_CYC_UP(`DPB_BUSY_ASSERT_FROM_SELECT_NS)
`define DPB_HOLD_CYC `DPB_CYC_UP(`DPB_WRITE_HOLD_AFTER_BUSY_NS)
`define DPB_SETUP_CYC 1
`define DPB_RECOVER_CYC 1
`define DPB_SYNC_CYC 4
`endif

/* File: shared/dpb_sync_if.sv */
// Synchronised busy level passed from the pin filter to the controller
interface dpb_sync_if;
  logic busy_n;
  modport src (output busy_n);
  modport dst (input  busy_n);
endinterface : dpb_sync_if

/* File: tb/dpb_checker.sv */
// Pin timing checks on the memory side of the port master
module dpb_checker (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       sel_n_o,
  input wire logic       wr_n_o,
  input wire logic       oe_n_o,
  input wire logic [9:0] addr_o,
  input wire logic       data_oe_o,
  input wire logic       busy_n_i
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Four cycles cover the wider of pulse width and turn-off plus set-up
  sequence pulse_s;
    !wr_n_o [*4];
  endsequence
  addr_steady_a: assert property ($changed(addr_o) |-> (sel_n_o || wr_n_o) &&
    $past(sel_n_o || wr_n_o)) else $error("address moved during write");
  data_late_a: assert property ($rose(data_oe_o) |-> $past(!wr_n_o))
    else $error("data driven before outputs off");
  data_clash_a: assert property (data_oe_o |-> oe_n_o)
    else $error("data driven into read");
  pulse_len_a: assert property ($fell(wr_n_o) |-> pulse_s)
    else $error("write pulse short");
  write_oe_a: assert property (!wr_n_o |-> !sel_n_o && oe_n_o)
    else $error("write qualifiers");
  hold_busy_a: assert property (!wr_n_o && $rose(busy_n_i) |-> !wr_n_o [*2])
    else $error("strobe dropped after busy");
endmodule : dpb_checker
bind dpb_port_master dpb_checker dpb_checker_inst (.clk_i(clk_i), .reset_i(reset_i),
  .sel_n_o(sel_n_o), .wr_n_o(wr_n_o), .oe_n_o(oe_n_o), .addr_o(addr_o),
  .data_oe_o(data_oe_o), .busy_n_i(busy_n_i));

/* File: tb/dpb_mem_model.sv */
// Behavioural memory port that loses same-address contention to a peer port
module dpb_mem_model #(
  parameter int BUSY_NS = 20
) (
  input  wire logic       sel_n_i,
  input  wire logic       wr_n_i,
  input  wire logic       oe_n_i,
  input  wire logic [9:0] addr_i,
  input  wire logic [7:0] dq_i,
  output logic      [7:0] q_o,
  output logic            busy_n_o,
  input  wire logic       peer_sel_n_i,
  input  wire logic [9:0] peer_addr_i
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [1024];
  logic [7:0] wd;
  logic [9:0] wa;
  wire        act = !sel_n_i && !wr_n_i;
  // Peer is always taken as first to arrive, so this port is the loser
  assign #BUSY_NS busy_n_o = !(!sel_n_i && !peer_sel_n_i &&
                               addr_i == peer_addr_i);
  always @* if (act) wa = addr_i;
  always @* if (act) wd = dq_i;
  // Write lands when the first strobe rises, and not while busy
  always @(negedge act) if (busy_n_o === 1'h1) mem[wa] = wd;
  // Undriven or blocked reads show the inverse so stale data cannot pass
  assign q_o = (!sel_n_i && !oe_n_i && wr_n_i && busy_n_o) ? mem[addr_i] :
               ~mem[addr_i];
endmodule : dpb_mem_model

/* File: tb/tb_dpb_port_master.sv */
// Self-checking bench for the port master against the memory port model
module tb_dpb_port_master;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_i, reset_i, req_valid_i, req_write_i, peer_sel_n;
  logic       req_ready_o, rsp_valid_o, rsp_blocked_o, sel_n_o, wr_n_o, oe_n_o, data_oe_o, busy_n;
  logic [9:0] req_addr_i, peer_addr, addr_o;
  logic [7:0] req_wdata_i, rsp_rdata_o, data_o, q;
  wire  [7:0] dq = data_oe_o ? data_o : q;
  int         errors, samples_checked;
  dpb_port_master dpb_port_master_inst (.clk_i(clk_i), .reset_i(reset_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .rsp_blocked_o(rsp_blocked_o), .sel_n_o(sel_n_o),
    .wr_n_o(wr_n_o), .oe_n_o(oe_n_o), .addr_o(addr_o), .data_i(dq), .data_o(data_o),
    .data_oe_o(data_oe_o), .busy_n_i(busy_n));
  dpb_mem_model dpb_mem_model_inst (.sel_n_i(sel_n_o), .wr_n_i(wr_n_o), .oe_n_i(oe_n_o),
    .addr_i(addr_o), .dq_i(dq), .q_o(q), .busy_n_o(busy_n), .peer_sel_n_i(peer_sel_n),
    .peer_addr_i(peer_addr));
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic access(input logic w, input logic [9:0] a, input logic [7:0] d,
                        input logic [7:0] er, input logic eb);
    int n = 0;
    @(negedge clk_i);
    {req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {1'h1, w, a, d};
    while (req_ready_o !== 1'h1) @(negedge clk_i);
    @(negedge clk_i);
    req_valid_i = 1'h0;
    while (rsp_valid_o !== 1'h1 && n < 100)
    begin
      @(negedge clk_i);
      n++;
    end
    check("rsp_valid", 8'h01, {7'h00, rsp_valid_o});
    check("rsp_blocked", {7'h00, eb}, {7'h00, rsp_blocked_o});
    if (!w) check("rsp_rdata", er, rsp_rdata_o);
  endtask : access
  task automatic plain_rw;
    access(1'h1, 10'h3FF, 8'hA5, 8'h00, 1'h0);
    access(1'h1, 10'h000, 8'h5A, 8'h00, 1'h0);
    access(1'h0, 10'h3FF, 8'h00, 8'hA5, 1'h0);
    access(1'h0, 10'h000, 8'h00, 8'h5A, 1'h0);
  endtask : plain_rw
  task automatic contend(input logic w, input logic [7:0] d);
    peer_addr = 10'h155;
    fork
      access(w, 10'h155, d, 8'hC3, 1'h1);
      begin
        repeat (15) @(negedge clk_i);
        peer_sel_n = 1'h1;
      end
    join
    access(1'h0, 10'h155, 8'h00, 8'hC3, 1'h0);
    {peer_sel_n, peer_addr} = {1'h0, 10'h200};
  endtask : contend
  task automatic conclude;
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial
  begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial
  begin
    #100000;
    errors++;
    conclude();
  end
  initial
  begin
    {reset_i, req_valid_i, req_write_i, req_addr_i, req_wdata_i} = {3'h4, 10'h000, 8'h00};
    {peer_sel_n, peer_addr} = {1'h0, 10'h200};
    repeat (5) @(negedge clk_i);
    reset_i = 1'h0;
    plain_rw();
    contend(1'h1, 8'hC3);
    contend(1'h0, 8'h00);
    conclude();
  end
endmodule : tb_dpb_port_master

/* File: verilog/dpb_busy_sync.sv */
// Three-stage synchroniser for the busy pin; level moves once stages two and three agree
module dpb_busy_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic busy_n_i,
  dpb_sync_if.src   sync
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } dpb_sync_st_t;

  dpb_sync_st_t st_q;
  dpb_sync_st_t st_d;

  always_comb
  begin
    st_d     = st_q;
    st_d.s1  = busy_n_i;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign sync.busy_n = st_q.lvl;
endmodule : dpb_busy_sync

/* File: verilog/dpb_port_master.sv */
// Bus master for one port of an asynchronous dual-port memory with busy arbitration
// Function
// - Address changes only with select or strobe high
// - Drive data only after outputs turn off
// - Strobe width covers turn-off plus data setup
// - Busy valid by write strobe start (strobe falls with select and is held through the busy window instead)
// - Hold strobe after busy release
`include "dpb_regs.svh"
module dpb_port_master (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       req_valid_i,
  output logic            req_ready_o,
  input  wire logic       req_write_i,
  input  wire logic [9:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  output logic            rsp_valid_o,
  output logic [7:0]      rsp_rdata_o,
  output logic            rsp_blocked_o,
  output logic            sel_n_o,
  output logic            wr_n_o,
  output logic            oe_n_o,
  output logic [9:0]      addr_o,
  input  wire logic [7:0] data_i,
  output logic [7:0]      data_o,
  output logic            data_oe_o,
  input  wire logic       busy_n_i
);
  localparam logic [3:0] PULSE_CYC = 4'(`DPB_PULSE_CYC);
  localparam logic [3:0] WAIT_CYC  = 4'(`DPB_BUSY_WAIT_CYC);
  localparam logic [3:0] HOLD_CYC  = 4'(`DPB_HOLD_CYC);
  localparam logic [3:0] SETUP_CYC = 4'(`DPB_SETUP_CYC);
  localparam logic [3:0] RCV_CYC   = 4'(`DPB_RECOVER_CYC);
  // Busy bound plus synchroniser latency: no strobe ends before busy is visible here
  localparam logic [3:0] BUSY_WIN_CYC = 4'(`DPB_BUSY_WAIT_CYC + `DPB_SYNC_CYC);

  typedef struct packed {
    dpb_pkg::dpb_state_t state;
    logic [3:0]          cnt;
    logic                write;
    logic                was_busy;
    logic                sel_n;
    logic                wr_n;
    logic                oe_n;
    logic [9:0]          addr;
    logic [7:0]          wdata;
    logic                data_oe;
    logic                rsp_valid;
    logic [7:0]          rdata;
    logic                blocked;
  } dpb_master_st_t;

  // Pins parked inactive and nothing driven onto the data bus
  localparam dpb_master_st_t ST_RESET = '{
    state:     dpb_pkg::DPB_IDLE,
    cnt:       4'h0,
    write:     1'b0,
    was_busy:  1'b0,
    sel_n:     1'b1,
    wr_n:      1'b1,
    oe_n:      1'b1,
    addr:      10'h000,
    wdata:     8'h00,
    data_oe:   1'b0,
    rsp_valid: 1'b0,
    rdata:     8'h00,
    blocked:   1'b0
  };

  dpb_master_st_t st_q;
  dpb_master_st_t st_d;
  dpb_sync_if     busy_sync ();
  logic           busy_n;

  dpb_busy_sync u_sync (
    .clk_i    (clk_i),
    .reset_i  (reset_i),
    .busy_n_i (busy_n_i),
    .sync     (busy_sync)
  );

  assign busy_n = busy_sync.busy_n;

  function automatic logic [3:0] dec(input logic [3:0] v);
    dec = (v == 4'h0) ? 4'h0 : 4'(v - 4'h1);
  endfunction : dec

  function automatic logic [3:0] strobe_cyc(input logic wr);
    // Reads need no pulse width, only the busy window
    strobe_cyc = wr ? `DPB_MAXI(PULSE_CYC, BUSY_WIN_CYC) : BUSY_WIN_CYC;
  endfunction : strobe_cyc

  function automatic logic [3:0] resume_cyc(input logic wr);
    // Blocked write completes after release; blocked read waits for valid data
    resume_cyc = wr ? HOLD_CYC : WAIT_CYC;
  endfunction : resume_cyc

  // Select, strobe and output enable rise on the same edge
  function automatic dpb_master_st_t park_pins(input dpb_master_st_t s);
    dpb_master_st_t r;
    r         = s;
    r.sel_n   = 1'b1;
    r.wr_n    = 1'b1;
    r.oe_n    = 1'b1;
    park_pins = r;
  endfunction : park_pins

  always_comb
  begin
    st_d           = st_q;
    st_d.rsp_valid = 1'b0;
    unique case (st_q.state)
      dpb_pkg::DPB_IDLE:
      begin
        if (req_valid_i)
        begin
          // Address moves only while select and strobe are both high
          st_d.addr     = req_addr_i;
          st_d.write    = req_write_i;
          st_d.wdata    = req_wdata_i;
          st_d.was_busy = 1'b0;
          st_d.cnt      = SETUP_CYC;
          st_d.state    = dpb_pkg::DPB_SETUP;
        end
      end
      dpb_pkg::DPB_SETUP:
      begin
        st_d.cnt = dec(st_q.cnt);
        if (st_q.cnt == 4'h0)
        begin
          // Strobe and select fall on the same edge with output enable held high: outputs never turn on during a write
          st_d.wr_n  = ~st_q.write;
          st_d.oe_n  = st_q.write;
          st_d.sel_n = 1'b0;
          // Long enough for device busy to settle before strobe counts
          st_d.cnt   = strobe_cyc(st_q.write);
          st_d.state = dpb_pkg::DPB_STROBE;
        end
      end
      dpb_pkg::DPB_STROBE:
      begin
        // Data driven only after outputs are off, one cycle into the strobe
        st_d.data_oe = st_q.write;
        if (!busy_n)
        begin
          // Blocked port: device drops the write; keep strobe until release
          st_d.was_busy = 1'b1;
          st_d.cnt      = resume_cyc(st_q.write);
        end
        else
        begin
          st_d.cnt = dec(st_q.cnt);
          if (st_q.cnt == 4'h0)
          begin
            if (!st_q.write)
            begin
              st_d.rdata = data_i;
            end
            // Write ends on this edge, with select and strobe rising together
            st_d       = park_pins(st_d);
            st_d.cnt   = RCV_CYC;
            st_d.state = dpb_pkg::DPB_HOLD;
          end
        end
      end
      dpb_pkg::DPB_HOLD:
      begin
        // Data held one cycle past strobe rise, then released
        st_d.data_oe = 1'b0;
        st_d.cnt     = dec(st_q.cnt);
        if (st_q.cnt == 4'h0)
        begin
          st_d.rsp_valid = 1'b1;
          st_d.blocked   = st_q.was_busy;
          st_d.state     = dpb_pkg::DPB_RECOVER;
        end
      end
      dpb_pkg::DPB_RECOVER:
      begin
        // One cycle with select high between accesses
        st_d.state = dpb_pkg::DPB_IDLE;
      end
      default:
      begin
        // An illegal state code parks select, strobe and output enable and releases the data bus before returning to idle
        st_d         = park_pins(st_d);
        st_d.data_oe = 1'b0;
        st_d.state   = dpb_pkg::DPB_IDLE;
      end
    endcase
  end

  // Asynchronous reset parks the pins at once, without waiting for a clock
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_q <= ST_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Ready comes straight from the state; every pin and data output is a flip-flop
  assign req_ready_o   = (st_q.state == dpb_pkg::DPB_IDLE);
  assign rsp_valid_o   = st_q.rsp_valid;
  assign rsp_rdata_o   = st_q.rdata;
  assign rsp_blocked_o = st_q.blocked;
  assign sel_n_o       = st_q.sel_n;
  assign wr_n_o        = st_q.wr_n;
  assign oe_n_o        = st_q.oe_n;
  assign addr_o        = st_q.addr;
  assign data_o        = st_q.wdata;
  assign data_oe_o     = st_q.data_oe;
endmodule : dpb_port_master
